// file: hw/host_bus_lane_steering.sv
/*
  Host parallel bus port: bus mode choice, byte lane steering by endian and register
  class, the bring-up state sequence, the asynchronous registers and a transmit and a
  receive word FIFO behind the FIFO data port.
  Assumes bus pins are asynchronous to clk_in and each strobe lasts at least three clocks.
*/
`timescale 1ns/10ps
// How it works
// - Config bits pick 16-bit strobe, 16-bit byte-enable or 8-bit bus mode.
// - Config byte: endian 0x04, byte-enable mode 0x02, narrow width 0x01.
// - Word registers: upper lane is first byte, lower lane last, any endian.
// - Endian clear: upper lane is even byte register or FIFO byte.
// - Endian set: lower lane is even byte register or FIFO byte.
// - FIFO even-lane byte goes out first; first received returns on even lane.
// - Registers split into word, FIFO and single byte classes.
// - After reset the port is cut off; power control read moves to Sleep.
// - Sleep allows access to every register not needing the internal clock.
// - Start big-endian; config byte also reachable at 0x74.
// - A new endian flag applies only after the endian commit register is read.
// - After global reset the default endian applies on the next commit read.
// - Wake-up time register is fully read-write in Sleep, all 16 bits.
// - Clock select: 0x00 12 MHz, 0x01 24 MHz, bit 7 external source.
// - Mode protect other than 0x56 write-protects clock select.
module host_bus_lane_steering
  import host_bus_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_hi_n_in,
  input wire logic wr_lo_n_in,
  input wire logic be_hi_n_in,
  input wire logic be_lo_n_in,
  input wire logic [6:0] addr_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_out,
  output bus_mode_e bus_mode_out,
  output dev_state_e dev_state_out,
  output logic endian_out,
  output logic [7:0] clock_input_select_out,
  output logic [15:0] wakeup_time_out,
  output logic go_active_out,
  output logic mtm_reset_out,
  output logic tx_valid_out,
  output logic [15:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic rx_valid_in,
  input wire logic [15:0] rx_data_in,
  output logic rx_ready_out
);

  typedef struct packed {
    dev_state_e state;
    bus_mode_e mode;
    logic endian;
    logic [7:0] cfg;
    logic [7:0] chip_rst;
    logic [7:0] pm;
    logic [15:0] wakeup;
    logic [7:0] protect;
    logic [7:0] clk_sel;
    logic [7:0] pend;
    logic ovf;
    logic rd_prev;
    logic wr_prev;
    logic [15:0] dout;
    logic oe;
  } state_s;

  // Edge memories start high: the synchroniser resets to zero, which must not look like a strobe.
  localparam state_s RESET_STATE = '{
    state: ST_CUT_OFF, mode: MODE_STROBE16, endian: 1'b0, cfg: CONFIG_RESET,
    chip_rst: CHIP_RESET_RESET, pm: PM_RESET, wakeup: WAKEUP_RESET,
    protect: MODE_PROTECT_RESET, clk_sel: CLK_SEL_RESET, pend: 8'h00, ovf: 1'b0,
    rd_prev: 1'b1, wr_prev: 1'b1, dout: 16'h0000, oe: 1'b0};

  state_s r_reg;
  state_s r_next;
  bus_pins_s raw;
  bus_pins_s p;
  logic push;
  logic pop;
  logic [15:0] push_data;
  logic tx_in_ready;
  logic rx_out_valid;
  logic [15:0] rx_out_data;

  // Swap the two byte lanes when asked.
  function automatic logic [15:0] lane_swap(input logic [15:0] w, input logic sw);
    return sw ? {w[7:0], w[15:8]} : w;
  endfunction : lane_swap

  // Word registers carry a first and last byte instead of two byte registers.
  function automatic logic is_word_reg(input logic [6:0] a);
    return a[6:1] == WAKEUP_HI_ADDR[6:1];
  endfunction : is_word_reg

  // FIFO data port pair.
  function automatic logic is_fifo_reg(input logic [6:0] a);
    return a[6:1] == FIFO_PORT_ADDR[6:1];
  endfunction : is_fifo_reg

  // Bus mode from the two config bits; narrow wins if both are set.
  function automatic bus_mode_e decode_mode(input logic [7:0] c);
    if (c[CFG_NARROW_BIT]) begin
      return MODE_NARROW8;
    end else if (c[CFG_BYTE_ENABLE_BIT]) begin
      return MODE_BYTE_EN16;
    end
    return MODE_STROBE16;
  endfunction : decode_mode

  // Every pin passes two flip-flops before the decode logic sees it.
  assign raw = '{cs_n: cs_n_in, rd_n: rd_n_in, wr_hi_n: wr_hi_n_in, wr_lo_n: wr_lo_n_in,
                 be_hi_n: be_hi_n_in, be_lo_n: be_lo_n_in, addr: addr_in, data: data_in};

  pin_sync #(
    .WIDTH($bits(bus_pins_s))
  ) u_pin_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(raw),
    .sync_out(p)
  );

  // Decode one bus access per strobe edge and update all port state.
  always_comb begin
    logic sel, wr_act, rd_act, lane_hi, lane_lo, wr_edge, rd_edge, narrow, swap, allowed;
    logic glob, ovf_clr;
    logic [6:0] base, a, hit;
    logic [7:0] d;
    logic [1:0] byte_en;
    logic [15:0] wd, canon;
    logic [7:0] rb [2];
    r_next = r_reg;
    sel = !p.cs_n;
    narrow = (r_reg.mode == MODE_NARROW8);
    glob = 1'b0;
    ovf_clr = 1'b0;
    a = 7'h00;
    d = 8'h00;
    rb[0] = 8'h00;
    rb[1] = 8'h00;
    wr_act = 1'b0;
    lane_hi = 1'b0;
    lane_lo = 1'b0;
    allowed = 1'b0;
    byte_en = 2'b00;
    wd = 16'h0000;
    // Strobe and lane meaning depend on the bus mode.
    case (r_reg.mode)
      MODE_BYTE_EN16: begin
        wr_act = sel && !p.wr_hi_n;
        lane_hi = !p.be_hi_n;
        lane_lo = !p.be_lo_n;
      end
      MODE_NARROW8: begin
        wr_act = sel && !p.wr_lo_n;
        lane_hi = 1'b0;
        lane_lo = 1'b1;
      end
      default: begin
        wr_act = sel && (!p.wr_hi_n || !p.wr_lo_n);
        lane_hi = !p.wr_hi_n;
        lane_lo = !p.wr_lo_n;
      end
    endcase
    rd_act = sel && !p.rd_n;
    wr_edge = wr_act && !r_reg.wr_prev;
    rd_edge = rd_act && !r_reg.rd_prev;
    r_next.wr_prev = wr_act;
    r_next.rd_prev = rd_act;
    base = narrow ? p.addr : {p.addr[6:1], 1'b0};
    hit = narrow ? p.addr : base;
    // In the 16-bit modes byte and FIFO registers follow the endian flag; word registers never swap.
    swap = r_reg.endian && !is_word_reg(base) && !narrow;
    canon = lane_swap(p.data, swap);
    if (narrow) begin
      byte_en = {!p.addr[0], p.addr[0]};
      wd = {p.data[7:0], p.data[7:0]};
    end else begin
      byte_en = swap ? {lane_lo, lane_hi} : {lane_hi, lane_lo};
      wd = canon;
    end
    base[0] = 1'b0;
    // Clocked registers need Active; the rest open up in Sleep.
    if (is_fifo_reg(base)) begin
      allowed = (r_reg.state == ST_ACTIVE);
    end else begin
      allowed = (r_reg.state != ST_CUT_OFF);
    end
    // Register writes, even byte first.
    if (wr_edge && allowed) begin
      for (int i = 0; i < 2; i++) begin
        a = {base[6:1], i[0]};
        d = (i == 0) ? wd[15:8] : wd[7:0];
        if (byte_en[1-i]) begin
          case (a)
            CHIP_RESET_ADDR: begin
              r_next.chip_rst = d & CHIP_RESET_MASK;
              glob = d[CHIP_GLOBAL_RESET_BIT];
            end
            PM_CTRL_ADDR: begin
              r_next.pm = d;
              if (d[PM_GO_ACTIVE_BIT] && r_reg.state == ST_SLEEP) begin
                r_next.state = ST_ACTIVE;
              end
            end
            WAKEUP_HI_ADDR: r_next.wakeup[15:8] = d;
            WAKEUP_LO_ADDR: r_next.wakeup[7:0] = d;
            MODE_PROTECT_ADDR: r_next.protect = d;
            CLK_SEL_ADDR: begin
              if (r_reg.protect == MODE_PROTECT_UNLOCK) begin
                r_next.clk_sel = d & CLK_SEL_MASK;
              end
            end
            CONFIG_ALIAS_ADDR, CONFIG_ADDR: r_next.cfg = d & CONFIG_MASK;
            FIFO_PORT_ADDR: r_next.pend = d;
            default: begin
            end
          endcase
        end
      end
    end
    // FIFO writes: a word with the even byte first, or two narrow byte writes.
    push = wr_edge && allowed && is_fifo_reg(base)
           && (narrow ? p.addr[0] : (byte_en == 2'b11));
    push_data = narrow ? {r_reg.pend, p.data[7:0]} : canon;
    // Register reads, captured at the start of the read strobe.
    if (rd_edge && allowed) begin
      for (int i = 0; i < 2; i++) begin
        a = {base[6:1], i[0]};
        case (a)
          CHIP_RESET_ADDR: rb[i] = r_reg.chip_rst;
          PM_CTRL_ADDR: rb[i] = r_reg.pm;
          WAKEUP_HI_ADDR: rb[i] = r_reg.wakeup[15:8];
          WAKEUP_LO_ADDR: rb[i] = r_reg.wakeup[7:0];
          MODE_PROTECT_ADDR: rb[i] = r_reg.protect;
          CLK_SEL_ADDR: rb[i] = r_reg.clk_sel;
          CONFIG_ALIAS_ADDR, CONFIG_ADDR: rb[i] = r_reg.cfg;
          FIFO_PORT_ADDR: rb[i] = rx_out_data[15:8];
          FIFO_PORT_ODD_ADDR: rb[i] = rx_out_data[7:0];
          FIFO_STATUS_ADDR: begin
            rb[i] = {2'b00, r_reg.state, 1'b0, r_reg.ovf, !rx_out_valid, !tx_in_ready};
            ovf_clr = 1'b1;
          end
          default: rb[i] = 8'h00;
        endcase
      end
    end
    pop = rd_edge && allowed && is_fifo_reg(base) && rx_out_valid
          && (!narrow || p.addr[0]);
    // Read data stays on the bus until the read strobe ends.
    if (rd_edge) begin
      r_next.oe = 1'b1;
      if (narrow) begin
        r_next.dout = {8'h00, p.addr[0] ? rb[1] : rb[0]};
      end else begin
        r_next.dout = lane_swap({rb[0], rb[1]}, swap);
      end
    end else if (!rd_act) begin
      r_next.oe = 1'b0;
    end
    // Reading power control ends the cut-off state.
    if (rd_edge && r_reg.state == ST_CUT_OFF && hit == PM_CTRL_ADDR) begin
      r_next.state = ST_SLEEP;
    end
    // Reading the commit register makes the stored endian flag live.
    if (rd_edge && allowed
        && (narrow ? (p.addr == ENDIAN_COMMIT_ADDR) : (base[6:1] == ENDIAN_COMMIT_ADDR[6:1]))) begin
      r_next.endian = r_reg.cfg[CFG_ENDIAN_BIT];
    end
    // A refused push marks overflow; a new overflow beats the read clear.
    r_next.ovf = (r_reg.ovf && !ovf_clr) || (push && !tx_in_ready);
    // Global reset restores defaults but keeps the live endian until commit.
    if (glob) begin
      r_next = RESET_STATE;
      r_next.endian = r_reg.endian;
      r_next.wr_prev = wr_act;
      r_next.rd_prev = rd_act;
      r_next.dout = r_reg.dout;
      r_next.oe = r_reg.oe;
    end
    r_next.mode = decode_mode(r_next.cfg);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= RESET_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Transmit words toward the USB side, first byte in the upper half.
  word_fifo #(
    .WIDTH(FIFO_WIDTH_DEF),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(push),
    .in_data_in(push_data),
    .in_ready_out(tx_in_ready),
    .out_valid_out(tx_valid_out),
    .out_data_out(tx_data_out),
    .out_ready_in(tx_ready_in)
  );

  // Received words from the USB side, first byte in the upper half.
  word_fifo #(
    .WIDTH(FIFO_WIDTH_DEF),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(rx_valid_in),
    .in_data_in(rx_data_in),
    .in_ready_out(rx_ready_out),
    .out_valid_out(rx_out_valid),
    .out_data_out(rx_out_data),
    .out_ready_in(pop)
  );

  // Outputs straight from the state register.
  assign data_out = r_reg.dout;
  assign data_oe_out = r_reg.oe;
  assign bus_mode_out = r_reg.mode;
  assign dev_state_out = r_reg.state;
  assign endian_out = r_reg.endian;
  assign clock_input_select_out = r_reg.clk_sel;
  assign wakeup_time_out = r_reg.wakeup;
  assign go_active_out = r_reg.pm[PM_GO_ACTIVE_BIT];
  assign mtm_reset_out = r_reg.chip_rst[7];

endmodule : host_bus_lane_steering

// file: common/host_bus_pkg.sv
/*
  Shared constants and types for the host parallel bus port: byte addresses of the
  registers, field positions, reset values, bus modes, device states and the pin bundle.
  Assumes a 7-bit byte address space and a 16-bit data bus toward the control CPU.
*/
package host_bus_pkg;

  // Byte addresses of the registers.
  localparam logic [6:0] CHIP_RESET_ADDR = 7'h11;
  localparam logic [6:0] PM_CTRL_ADDR = 7'h12;
  localparam logic [6:0] WAKEUP_HI_ADDR = 7'h14;
  localparam logic [6:0] WAKEUP_LO_ADDR = 7'h15;
  localparam logic [6:0] FIFO_PORT_ADDR = 7'h60;
  localparam logic [6:0] FIFO_PORT_ODD_ADDR = 7'h61;
  localparam logic [6:0] FIFO_STATUS_ADDR = 7'h62;
  localparam logic [6:0] MODE_PROTECT_ADDR = 7'h71;
  localparam logic [6:0] CLK_SEL_ADDR = 7'h73;
  localparam logic [6:0] CONFIG_ALIAS_ADDR = 7'h74;
  localparam logic [6:0] CONFIG_ADDR = 7'h75;
  localparam logic [6:0] ENDIAN_COMMIT_ADDR = 7'h77;

  // Field positions.
  localparam int CFG_NARROW_BIT = 0;
  localparam int CFG_BYTE_ENABLE_BIT = 1;
  localparam int CFG_ENDIAN_BIT = 2;
  localparam int CHIP_GLOBAL_RESET_BIT = 0;
  localparam int PM_GO_ACTIVE_BIT = 6;
  localparam int STAT_TX_FULL_BIT = 0;
  localparam int STAT_RX_EMPTY_BIT = 1;
  localparam int STAT_OVERFLOW_BIT = 2;

  // Reset values and masks.
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_MASK = 8'h07;
  localparam logic [7:0] CHIP_RESET_RESET = 8'h80;
  localparam logic [7:0] CHIP_RESET_MASK = 8'h80;
  localparam logic [7:0] PM_RESET = 8'h00;
  localparam logic [15:0] WAKEUP_RESET = 16'h0000;
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam logic [7:0] CLK_SEL_MASK = 8'h83;
  localparam logic [7:0] MODE_PROTECT_UNLOCK = 8'h56;
  localparam logic [7:0] MODE_PROTECT_RESET = 8'h56;

  // Data path buffer shape.
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int FIFO_WIDTH_DEF = 16;

  typedef enum logic [1:0] {MODE_STROBE16, MODE_BYTE_EN16, MODE_NARROW8} bus_mode_e;
  typedef enum logic [1:0] {ST_CUT_OFF, ST_SLEEP, ST_ACTIVE} dev_state_e;

  // Bus pins as sampled from the CPU side.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_hi_n;
    logic wr_lo_n;
    logic be_hi_n;
    logic be_lo_n;
    logic [6:0] addr;
    logic [15:0] data;
  } bus_pins_s;

endpackage : host_bus_pkg

// file: hw/pin_sync.sv
/*
  Two-stage synchroniser for a vector of asynchronous pin levels.
  Assumes every bit is a level that holds long enough to be sampled twice.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  // The first stage only feeds the second stage.
  always_comb begin
    r_next.first = async_in;
    r_next.second = r_reg.first;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.second;

endmodule : pin_sync

// file: hw/word_fifo.sv
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes DEPTH is a power of two; data leaves in the order it entered.
*/
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ptr_s;

  ptr_s r_reg;
  ptr_s r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Full when the pointers differ only in the wrap bit, empty when equal.
  assign in_ready_out = !((r_reg.wr[AW] != r_reg.rd[AW]) && (r_reg.wr[AW-1:0] == r_reg.rd[AW-1:0]));
  assign out_valid_out = (r_reg.wr != r_reg.rd);
  assign out_data_out = mem[r_reg.rd[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;

  // Pointer advance.
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wr = r_reg.wr + 1'b1;
    end
    if (pop) begin
      r_next.rd = r_reg.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Storage needs no reset; only slots behind the write pointer are read.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[r_reg.wr[AW-1:0]] <= in_data_in;
    end
  end

endmodule : word_fifo

// file: sim/host_bus_lane_steering_props.sv
/*
  Checker for the host parallel bus port: bring-up states, read answer timing,
  endian commit gating, mode and clock select updates and transmit stream holding.
  Assumes it is bound to the port's top module and sees only its pins.
*/
`timescale 1ns/10ps
module host_bus_lane_steering_props
  import host_bus_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_hi_n_in,
  input wire logic wr_lo_n_in,
  input wire logic [6:0] addr_in,
  input wire logic data_oe_out,
  input wire bus_mode_e bus_mode_out,
  input wire dev_state_e dev_state_out,
  input wire logic endian_out,
  input wire logic [7:0] clock_input_select_out,
  input wire logic go_active_out,
  input wire logic tx_valid_out,
  input wire logic [15:0] tx_data_out,
  input wire logic tx_ready_in
);
  logic [3:0] commit_age_reg;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  // Counts clocks since the pins last showed a read of the commit register.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      commit_age_reg <= 4'hf;
    end else if (!cs_n_in && !rd_n_in && addr_in[6:1] == 6'h3b) begin
      commit_age_reg <= 4'h0;
    end else if (commit_age_reg != 4'hf) begin
      commit_age_reg <= commit_age_reg + 4'h1;
    end
  end

  cut_off_start_a: assert property ($rose(nrst_in) |-> dev_state_out == ST_CUT_OFF
    && !endian_out && bus_mode_out == MODE_STROBE16) else $error("no clean start state");
  sleep_entry_a: assert property (($past(dev_state_out) == ST_CUT_OFF
    && dev_state_out != ST_CUT_OFF) |-> dev_state_out == ST_SLEEP && !$past(rd_n_in, 3)
    && ($past(addr_in, 3) >> 1) == 7'h09) else $error("cut-off left without power read");
  active_entry_a: assert property (($past(dev_state_out) == ST_SLEEP
    && dev_state_out == ST_ACTIVE) |-> go_active_out) else $error("active without go bit");
  read_answer_a: assert property ($rose(data_oe_out) |-> !$past(rd_n_in, 3)
    && !$past(cs_n_in, 3)) else $error("bus driven without a read");
  read_release_a: assert property ($rose(rd_n_in) |-> ##[1:4] !data_oe_out)
    else $error("bus not released after read");
  commit_gate_a: assert property ($changed(endian_out) |-> commit_age_reg < 4'h8)
    else $error("endian changed without commit read");
  mode_write_a: assert property ($changed(bus_mode_out)
    |-> !$past(wr_hi_n_in, 3) || !$past(wr_lo_n_in, 3)) else $error("mode changed unwritten");
  clk_sel_write_a: assert property ($changed(clock_input_select_out)
    |-> !$past(wr_hi_n_in, 3) || !$past(wr_lo_n_in, 3)) else $error("clock select unwritten");
  clk_sel_bits_a: assert property ((clock_input_select_out & 8'h7c) == 8'h00)
    else $error("clock select holds unused bits");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out
    && $stable(tx_data_out)) else $error("transmit word dropped while stalled");
endmodule : host_bus_lane_steering_props

bind host_bus_lane_steering host_bus_lane_steering_props u_props (.*);

// file: sim/cpu_bus_model.sv
/*
  Control CPU model: drives the host port pins one access at a time.
  Assumes the bench calls acc from one process; pins move after falling edges.
*/
`timescale 1ns/10ps
module cpu_bus_model (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic [3:0] strobe_n_out,
  output logic [6:0] addr_out,
  output logic [15:0] data_out,
  input wire logic [15:0] rdata_in
);
  // Idle pins: deselected, data showing the inverse of its reset pattern.
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    strobe_n_out = 4'hf;
    addr_out = 7'h7f;
    data_out = 16'hffff;
  end

  // One access held five clocks, then four idle clocks; strobes {wr_hi,wr_lo,be_hi,be_lo}.
  task automatic acc(input logic rd, input logic [6:0] a, input logic [15:0] d,
                     input logic [3:0] st, output logic [15:0] q);
    @(negedge clk_in);
    addr_out = a;
    data_out = rd ? ~data_out : d;
    cs_n_out = 1'b0;
    rd_n_out = !rd;
    strobe_n_out = ~st;
    repeat (5) @(posedge clk_in);
    q = rdata_in;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    strobe_n_out = 4'hf;
    data_out = ~data_out;
    addr_out = ~a;
    repeat (4) @(posedge clk_in);
  endtask : acc
endmodule : cpu_bus_model

// file: sim/tb_host_bus_lane_steering.sv
/*
  Testbench for the host parallel bus port: bring-up, lanes, registers, FIFO, modes.
  Assumes the CPU model for bus cycles and drives the USB side streams itself.
*/
`timescale 1ns/10ps
module tb_host_bus_lane_steering
  import host_bus_pkg::*;
;
  logic clk_in, nrst_in, cs_n_in, rd_n_in, wr_hi_n_in, wr_lo_n_in, be_hi_n_in, be_lo_n_in;
  logic [6:0] addr_in;
  logic [15:0] data_in, data_out, wakeup_time_out, tx_data_out, rx_data_in, q;
  logic data_oe_out, endian_out, go_active_out, mtm_reset_out, tx_valid_out;
  logic tx_ready_in, rx_valid_in, rx_ready_out;
  logic [7:0] clock_input_select_out;
  bus_mode_e bus_mode_out;
  dev_state_e dev_state_out;
  int error_cnt = 0;
  int total_checks = 0;

  host_bus_lane_steering #(.FIFO_DEPTH(8)) u_dut (.*);
  cpu_bus_model u_cpu (.clk_in(clk_in), .cs_n_out(cs_n_in), .rd_n_out(rd_n_in),
    .strobe_n_out({wr_hi_n_in, wr_lo_n_in, be_hi_n_in, be_lo_n_in}),
    .addr_out(addr_in), .data_out(data_in), .rdata_in(data_out));

  // Clock of 40 ns period.
  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [3:0] st);
    logic [15:0] r;
    u_cpu.acc(1'b0, a, d, st, r);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    u_cpu.acc(1'b1, a, 16'h0000, 4'h0, r);
  endtask : rd

  task automatic t_cutoff();
    chk("state", dev_state_out, ST_CUT_OFF);
    chk("endian", endian_out, 1'b0);
    chk("mtm", mtm_reset_out, 1'b1);
    wr(WAKEUP_HI_ADDR, 16'h5a5a, 4'hc);
    chk("wake cut", wakeup_time_out, 16'h0000);
    rd(PM_CTRL_ADDR, q);
    chk("state", dev_state_out, ST_SLEEP);
    chk("oe idle", data_oe_out, 1'b0);
    $display("test cutoff done");
  endtask : t_cutoff

  task automatic t_endian();
    rd(ENDIAN_COMMIT_ADDR, q);
    wr(CONFIG_ALIAS_ADDR, 16'h0400, 4'h8);
    chk("endian early", endian_out, 1'b0);
    rd(ENDIAN_COMMIT_ADDR, q);
    chk("endian", endian_out, 1'b1);
    chk("mode", bus_mode_out, MODE_STROBE16);
    $display("test endian done");
  endtask : t_endian

  task automatic t_wakeup();
    logic [15:0] p [2] = '{16'h1234, 16'hedcb};
    for (int i = 0; i < 2; i++) begin
      wr(WAKEUP_HI_ADDR, p[i], 4'hc);
      chk("wake", wakeup_time_out, p[i]);
      rd(WAKEUP_HI_ADDR, q);
      chk("wake rd", q, p[i]);
    end
    $display("test wakeup done");
  endtask : t_wakeup

  task automatic t_clksel();
    logic [7:0] v [4] = '{8'h00, 8'h01, 8'h80, 8'h81};
    for (int i = 0; i < 4; i++) begin
      wr(CLK_SEL_ADDR, {v[i], 8'h00}, 4'h8);
      chk("clk sel", clock_input_select_out, v[i]);
      rd(CLK_SEL_ADDR, q);
      chk("clk rd", q, {v[i], 8'h00});
    end
    wr(MODE_PROTECT_ADDR, 16'h0000, 4'h8);
    wr(CLK_SEL_ADDR, 16'h0100, 4'h8);
    chk("clk lock", clock_input_select_out, 8'h81);
    wr(MODE_PROTECT_ADDR, 16'h5600, 4'h8);
    wr(CLK_SEL_ADDR, 16'h0000, 4'h8);
    chk("clk open", clock_input_select_out, 8'h00);
    $display("test clksel done");
  endtask : t_clksel

  task automatic t_fifo();
    logic [3:0] n;
    wr(PM_CTRL_ADDR, 16'h0040, 4'h4);
    chk("state", dev_state_out, ST_ACTIVE);
    chk("go", go_active_out, 1'b1);
    for (int i = 0; i < 9; i++) begin
      n = 4'(i);
      wr(FIFO_PORT_ADDR, {4'h8, n, 4'h0, n}, 4'hc);
    end
    rd(FIFO_STATUS_ADDR, q);
    chk("status", q, 16'h0027);
    for (int i = 0; i < 8; i++) begin
      n = 4'(i);
      chk("tx valid", tx_valid_out, 1'b1);
      chk("tx data", tx_data_out, {4'h0, n, 4'h8, n});
      @(negedge clk_in);
      tx_ready_in = 1'b1;
      @(negedge clk_in);
      tx_ready_in = 1'b0;
    end
    chk("tx empty", tx_valid_out, 1'b0);
    chk("rx ready", rx_ready_out, 1'b1);
    rx_valid_in = 1'b1;
    rx_data_in = 16'hc1c2;
    @(negedge clk_in);
    rx_valid_in = 1'b0;
    rd(FIFO_PORT_ADDR, q);
    chk("rx rd", q, 16'hc2c1);
    rd(FIFO_STATUS_ADDR, q);
    chk("status", q, 16'h0022);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_modes();
    wr(CONFIG_ADDR, 16'h0200, 4'h8);
    chk("mode", bus_mode_out, MODE_BYTE_EN16);
    wr(CONFIG_ADDR, 16'h0100, 4'ha);
    chk("mode", bus_mode_out, MODE_NARROW8);
    wr(CHIP_RESET_ADDR, 16'h0001, 4'h4);
    chk("state", dev_state_out, ST_CUT_OFF);
    chk("mode", bus_mode_out, MODE_STROBE16);
    chk("endian kept", endian_out, 1'b1);
    rd(PM_CTRL_ADDR, q);
    rd(ENDIAN_COMMIT_ADDR, q);
    chk("endian", endian_out, 1'b0);
    wr(CLK_SEL_ADDR, 16'h0001, 4'h4);
    chk("clk sel", clock_input_select_out, 8'h01);
    rd(CLK_SEL_ADDR, q);
    chk("clk rd", q, 16'h0001);
    $display("test modes done");
  endtask : t_modes

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Main sequence: reset for two clocks, then each scenario in turn.
  initial begin
    nrst_in = 1'b0;
    tx_ready_in = 1'b0;
    rx_valid_in = 1'b0;
    rx_data_in = 16'h0000;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    t_cutoff();
    t_endian();
    t_wakeup();
    t_clksel();
    t_fifo();
    t_modes();
    finish_test();
  end

  // Watchdog well beyond the roughly four hundred clocks the scenarios need.
  initial begin
    #800000;
    error_cnt++;
    finish_test();
  end
endmodule : tb_host_bus_lane_steering
